// File: fsps_consts.vh
// Constants for the flash self-programming sequencer
`ifndef FSPS_CONSTS_VH
`define FSPS_CONSTS_VH
// Control/status bit positions
`define FSPS_BIT_IRQ_EN 7
`define FSPS_BIT_BUSY 6
`define FSPS_BIT_SIG_READ 5
`define FSPS_BIT_REEN 4
`define FSPS_BIT_LOCK 3
`define FSPS_BIT_WRITE 2
`define FSPS_BIT_ERASE 1
`define FSPS_BIT_EN 0
// Command codes in the low five control bits
`define FSPS_CMD_LOAD 5'h01
`define FSPS_CMD_ERASE 5'h03
`define FSPS_CMD_WRITE 5'h05
`define FSPS_CMD_LOCK 5'h09
`define FSPS_CMD_REEN 5'h11
`define FSPS_CTRL_RESET 8'h00
// Arming windows in clock cycles
`define FSPS_STORE_WINDOW 3'h4
`define FSPS_LOAD_MIN_LEFT 3'h2
// Readback pointer values
`define FSPS_RB_FUSE_LOW 16'h0000
`define FSPS_RB_LOCK 16'h0001
`define FSPS_RB_FUSE_EXT 16'h0002
`define FSPS_RB_FUSE_HIGH 16'h0003
`define FSPS_RB_UNUSED_HI 2'h3
`define FSPS_RB_EXT_HI 4'hF
`define FSPS_RB_NONE 8'hFF
// Value of a buffer word that holds no loaded data
`define FSPS_BUF_ERASED 16'hFFFF
// Programming time, in microseconds, and clock rate in MHz
`define FSPS_PROG_MIN_US 3700
`define FSPS_PROG_MAX_US 4500
`define FSPS_CLK_MHZ 10
// Sequencer states
`define FSPS_ST_IDLE 1'b0
`define FSPS_ST_PROG 1'b1
`endif

// File: fsps_sequencer.v
// Flash self-programming sequencer: command arming, page buffer, timed operations, readback
`include "fsps_consts.vh"
`default_nettype none

module fsps_sequencer #(
    parameter WORD_W = 5,          // Word-in-page field width, words per page = 2**WORD_W
    parameter NONUPD_FIRST_PAGE = 96, // First page of the non-updatable section
    parameter PROG_CYCLES = `FSPS_PROG_MIN_US * `FSPS_CLK_MHZ // Operation length in clocks
) (
    input wire i_clk_sys,
    input wire i_reset_n,
    input wire i_ctrl_wr,
    input wire [7:0] i_ctrl_wdata,
    output wire [7:0] o_ctrl_rdata,
    input wire i_store_prog,
    input wire i_load_prog,
    input wire [15:0] i_zptr,
    input wire [7:0] i_data_low,
    input wire [7:0] i_data_high,
    input wire i_eeprom_write_busy,
    input wire [7:0] i_fuse_low,
    input wire [7:0] i_fuse_high,
    input wire [3:0] i_fuse_ext,
    input wire [5:0] i_lock_bits,
    input wire [WORD_W-1:0] i_buf_raddr,
    output reg [15:0] o_buf_rdata,
    output wire o_irq_req,
    output wire o_cpu_halt,
    output wire o_updatable_blocked,
    output reg o_op_erase,
    output reg o_op_write,
    output reg o_op_lock,
    output reg [15-WORD_W-1:0] o_op_page,
    output reg [3:0] o_op_lock_data,
    output reg o_op_done,
    output reg o_rb_valid,
    output reg [7:0] o_rb_data
);

    localparam PAGE_W = 15 - WORD_W;   // Page field width
    localparam WORDS = 1 << WORD_W;    // Buffer depth
    localparam CNT_W = 17;             // Wide enough for the default operation length
    // Last count value, cut to the counter width on purpose
    // A longer operation needs CNT_W raised together with PROG_CYCLES
    localparam [31:0] PROG_LAST_FULL = PROG_CYCLES - 1;
    localparam [CNT_W-1:0] PROG_LAST = PROG_LAST_FULL[CNT_W-1:0];

    // Control/status bits
    // Every bit here resets to zero
    reg irq_en;                  // Ready interrupt enable
    reg section_busy_flag;       // Updatable section busy
    reg section_read_reenable;   // Re-enable command armed
    reg lock_set_cmd;            // Lock set / readback armed
    reg page_write_cmd;          // Page write armed or running
    reg page_erase_cmd;          // Page erase armed or running
    reg self_prog_enable;        // Store armed or operation running
    reg [2:0] arm_cnt;           // Cycles left in the arming window
    reg state;                   // Idle or timed programming
    reg [CNT_W-1:0] prog_cnt;    // Programming time counter
    reg op_nonupd;               // Running operation targets non-updatable section
    reg [15:0] page_buf [0:WORDS-1]; // Temporary page buffer
    reg [WORDS-1:0] loaded;      // Word already loaded since last clear

    // Pointer fields; bit 0 is the byte select and is ignored by stores
    // A page holds 2**WORD_W words
    wire [WORD_W-1:0] word_in_page_field = i_zptr[WORD_W:1];
    wire [PAGE_W-1:0] page_index_field = i_zptr[15:WORD_W+1];

    // Low five bits of a control write pick the command
    wire [4:0] cmd_code = i_ctrl_wdata[4:0];
    // Only the defined combinations arm anything; signature read is not supported here
    wire cmd_legal = (cmd_code == `FSPS_CMD_LOAD) || (cmd_code == `FSPS_CMD_ERASE) ||
                     (cmd_code == `FSPS_CMD_WRITE) || (cmd_code == `FSPS_CMD_LOCK) ||
                     (cmd_code == `FSPS_CMD_REEN);
    // No arming while a previous command is armed or running, or EEPROM is busy
    wire arm_ok = i_ctrl_wr && cmd_legal && !self_prog_enable &&
                  !i_eeprom_write_busy && !i_ctrl_wdata[`FSPS_BIT_SIG_READ];

    // Command decode at the store or load edge
    // A store while EEPROM is busy is dropped, but the window keeps running
    // Only one command bit can be set in an armed command
    wire armed = (state == `FSPS_ST_IDLE) && self_prog_enable && (arm_cnt != 3'h0);
    wire store_go = armed && i_store_prog && !i_eeprom_write_busy;
    // A plain enable with no command bit means a buffer load
    wire is_load = !section_read_reenable && !lock_set_cmd && !page_write_cmd && !page_erase_cmd;
    wire do_load = store_go && is_load;
    wire do_erase = store_go && page_erase_cmd;
    wire do_write = store_go && page_write_cmd;
    wire do_lock = store_go && lock_set_cmd;
    wire do_reen = store_go && section_read_reenable;
    // Readback only in the first three cycles of the window
    wire rb_go = armed && lock_set_cmd && i_load_prog && (arm_cnt >= `FSPS_LOAD_MIN_LEFT) &&
                 !i_eeprom_write_busy;
    // The window ends at the fourth edge after arming if nothing used it
    wire window_end = armed && (arm_cnt == 3'h1) && !store_go && !rb_go;
    // Operation ends on the first edge that sees the counter at its last value
    wire prog_end = (state == `FSPS_ST_PROG) && (prog_cnt == PROG_LAST);
    // Pages from NONUPD_FIRST_PAGE up hold code that runs while the rest is busy
    wire page_is_nonupd = (page_index_field >= NONUPD_FIRST_PAGE);
    // Any EEPROM activity while words are loaded throws the whole buffer away
    wire ee_discard = i_eeprom_write_busy && (|loaded);

    // Status read; bit 5 always reads zero since signature read is refused
    assign o_ctrl_rdata = {irq_en, section_busy_flag, 1'b0, section_read_reenable,
                           lock_set_cmd, page_write_cmd, page_erase_cmd, self_prog_enable};
    // Level request for as long as the enable bit is low
    assign o_irq_req = irq_en && !self_prog_enable;
    // Lock programming never halts nor blocks
    assign o_cpu_halt = (state == `FSPS_ST_PROG) && op_nonupd && !o_op_lock;
    // The busy flag itself is the read block for the updatable section
    assign o_updatable_blocked = section_busy_flag;

    // Control bits, arming window and timed operation
    // One process owns every control bit, so no bit has two drivers
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            irq_en <= 1'b0;
            section_busy_flag <= 1'b0;
            section_read_reenable <= 1'b0;
            lock_set_cmd <= 1'b0;
            page_write_cmd <= 1'b0;
            page_erase_cmd <= 1'b0;
            self_prog_enable <= 1'b0;
            arm_cnt <= 3'h0;
            state <= `FSPS_ST_IDLE;
            // An operation cut by reset is simply abandoned
            prog_cnt <= {CNT_W{1'b0}};
            op_nonupd <= 1'b0;
            o_op_erase <= 1'b0;
            o_op_write <= 1'b0;
            o_op_lock <= 1'b0;
            o_op_page <= {PAGE_W{1'b0}};
            o_op_lock_data <= 4'h0;
            o_op_done <= 1'b0;
        end else begin
            o_op_done <= 1'b0;
            // Interrupt enable is always writable
            if (i_ctrl_wr) begin
                irq_en <= i_ctrl_wdata[`FSPS_BIT_IRQ_EN];
            end
            case (state)
                `FSPS_ST_IDLE: begin
                    // Arming needs enable low, so it never meets a store in the same cycle
                    if (arm_ok) begin
                        // Arm the store for four cycles
                        self_prog_enable <= 1'b1;
                        section_read_reenable <= i_ctrl_wdata[`FSPS_BIT_REEN];
                        lock_set_cmd <= i_ctrl_wdata[`FSPS_BIT_LOCK];
                        page_write_cmd <= i_ctrl_wdata[`FSPS_BIT_WRITE];
                        page_erase_cmd <= i_ctrl_wdata[`FSPS_BIT_ERASE];
                        arm_cnt <= `FSPS_STORE_WINDOW;
                    end else if (do_erase || do_write) begin
                        // Latch the page; the pointer is free from here on
                        o_op_page <= page_index_field;
                        op_nonupd <= page_is_nonupd;
                        o_op_erase <= do_erase;
                        o_op_write <= do_write;
                        // Enable and command bit stay high through the operation
                        state <= `FSPS_ST_PROG;
                        prog_cnt <= {CNT_W{1'b0}};
                        arm_cnt <= 3'h0;
                        // Only the updatable section is blocked while the array is busy
                        if (!page_is_nonupd) begin
                            section_busy_flag <= 1'b1;
                        end
                    end else if (do_lock) begin
                        // Pointer takes no part; only data bits 5..2 matter
                        o_op_lock_data <= i_data_low[5:2];
                        o_op_lock <= 1'b1;
                        op_nonupd <= 1'b0;
                        state <= `FSPS_ST_PROG;
                        prog_cnt <= {CNT_W{1'b0}};
                        arm_cnt <= 3'h0;
                    end else if (store_go || rb_go || window_end) begin
                        // Load, re-enable, readback or timeout all end the command
                        self_prog_enable <= 1'b0;
                        section_read_reenable <= 1'b0;
                        lock_set_cmd <= 1'b0;
                        page_write_cmd <= 1'b0;
                        page_erase_cmd <= 1'b0;
                        arm_cnt <= 3'h0;
                        // A load or a re-enable frees the updatable section
                        if (do_load || do_reen) begin
                            section_busy_flag <= 1'b0;
                        end
                    end else if (arm_cnt != 3'h0) begin
                        arm_cnt <= arm_cnt - 3'h1;
                    end
                end
                `FSPS_ST_PROG: begin
                    // Control writes other than the interrupt enable are ignored here
                    // Fixed length inside the allowed 3.7 to 4.5 ms band
                    prog_cnt <= prog_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
                    if (prog_end) begin
                        state <= `FSPS_ST_IDLE;
                        self_prog_enable <= 1'b0;
                        lock_set_cmd <= 1'b0;
                        page_write_cmd <= 1'b0;
                        page_erase_cmd <= 1'b0;
                        o_op_erase <= 1'b0;
                        o_op_write <= 1'b0;
                        o_op_lock <= 1'b0;
                        o_op_done <= 1'b1;
                        // Busy flag stays set until software re-enables the section or loads a word
                        op_nonupd <= 1'b0;
                    end
                end
                default: begin
                    state <= `FSPS_ST_IDLE;
                end
            endcase
        end
    end

    // Loaded-word flags: cleared after a write, on re-enable, on EEPROM write, at reset
    // Clear beats set; a store is blocked during EEPROM activity, so the two never meet
    // Reset empties the buffer so no word survives a restart
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            loaded <= {WORDS{1'b0}};
        end else if ((prog_end && o_op_write) || do_reen || ee_discard) begin
            loaded <= {WORDS{1'b0}};
        end else if (do_load && !loaded[word_in_page_field]) begin
            // Software is expected to load each word once only
            loaded[word_in_page_field] <= 1'b1;
        end
    end

    // Buffer storage; a cleared word reads as erased flash
    // No reset on the array itself; the loaded flags mask stale words
    always @(posedge i_clk_sys) begin
        if (do_load && !loaded[word_in_page_field]) begin
            page_buf[word_in_page_field] <= {i_data_high, i_data_low};
        end
    end

    // Buffer read port for the flash array during page write
    // One cycle from address to data; unloaded words read as erased
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_buf_rdata <= `FSPS_BUF_ERASED;
        end else if (loaded[i_buf_raddr]) begin
            o_buf_rdata <= page_buf[i_buf_raddr];
        end else begin
            o_buf_rdata <= `FSPS_BUF_ERASED;
        end
    end

    // Fuse and lock readback, byte addressed by the full pointer
    // Comparing all sixteen bits lets bit 0 pick between neighbouring bytes
    // The byte is held until the next readback
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rb_valid <= 1'b0;
            o_rb_data <= `FSPS_RB_NONE;
        end else begin
            o_rb_valid <= rb_go;
            if (rb_go) begin
                case (i_zptr)
                    `FSPS_RB_FUSE_LOW: o_rb_data <= i_fuse_low;
                    `FSPS_RB_LOCK: o_rb_data <= {`FSPS_RB_UNUSED_HI, i_lock_bits};
                    `FSPS_RB_FUSE_EXT: o_rb_data <= {`FSPS_RB_EXT_HI, i_fuse_ext};
                    `FSPS_RB_FUSE_HIGH: o_rb_data <= i_fuse_high;
                    default: o_rb_data <= `FSPS_RB_NONE;
                endcase
            end
        end
    end

    // Page write assumes word field and bit 0 zero and an erased page
    // Lock data spare bits and pointer value are left to software
    // Signature row reads are refused: bit 5 set in a control write arms nothing
    // A reset cuts a running operation short; the array side must cope with that

endmodule

`default_nettype wire

// File: fsps_asserts.sv
// Port checker for the flash self-programming sequencer, bound to its top module
`default_nettype none
module fsps_asserts #(
    parameter int WORD_W = 5,
    parameter int NONUPD_FIRST_PAGE = 96,
    parameter int PROG_CYCLES = 20
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_store_prog,
    input wire logic i_load_prog,
    input wire logic [15:0] i_zptr,
    input wire logic [7:0] i_data_low,
    input wire logic i_eeprom_write_busy,
    input wire logic [7:0] o_ctrl_rdata,
    input wire logic o_irq_req,
    input wire logic o_cpu_halt,
    input wire logic o_updatable_blocked,
    input wire logic o_op_erase,
    input wire logic o_op_write,
    input wire logic o_op_lock,
    input wire logic [15-WORD_W-1:0] o_op_page,
    input wire logic [3:0] o_op_lock_data,
    input wire logic o_op_done,
    input wire logic o_rb_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    // Window from two cycles below to one cycle above, since the start edge may count or not
    localparam int LO = PROG_CYCLES - 2;
    localparam int HI = PROG_CYCLES + 1;
    wire logic pgm = o_op_erase | o_op_write; // Page erase or page write running
    wire logic any_op = pgm | o_op_lock; // Any timed operation running
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    property p_irq_level; o_irq_req == (o_ctrl_rdata[7] && !o_ctrl_rdata[0]); endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq request level wrong");
    property p_arm_timeout; $rose(o_ctrl_rdata[0]) ##0 (!i_store_prog && !i_load_prog) [*4] |=> !o_ctrl_rdata[0]; endproperty
    a_arm_timeout: assert property (p_arm_timeout) else $error("enable outlived its window");
    property p_en_op; pgm |-> o_ctrl_rdata[0]; endproperty
    a_en_op: assert property (p_en_op) else $error("enable dropped during operation");
    property p_op_len; $rose(any_op) |-> ##[LO:HI] o_op_done; endproperty
    a_op_len: assert property (p_op_len) else $error("operation length wrong");
    property p_halt; o_cpu_halt |-> pgm && (o_op_page >= NONUPD_FIRST_PAGE); endproperty
    a_halt: assert property (p_halt) else $error("halt without protected page operation");
    property p_lock_free; $rose(o_op_lock) |-> !o_cpu_halt && $stable(o_updatable_blocked); endproperty
    a_lock_free: assert property (p_lock_free) else $error("lock programming blocked reads");
    property p_block; pgm && (o_op_page < NONUPD_FIRST_PAGE) |-> o_updatable_blocked && o_ctrl_rdata[6]; endproperty
    a_block: assert property (p_block) else $error("updatable section not blocked during operation");
    property p_latch; $past(pgm) && pgm |-> $stable(o_op_page); endproperty
    a_latch: assert property (p_latch) else $error("page moved during operation");
    property p_page; $rose(pgm) |-> o_op_page == $past(i_zptr[15:WORD_W+1]); endproperty
    a_page: assert property (p_page) else $error("page field wrong");
    property p_lock_data; $rose(o_op_lock) |-> o_op_lock_data == $past(i_data_low[5:2]); endproperty
    a_lock_data: assert property (p_lock_data) else $error("lock data wrong");
    property p_ee; $rose(any_op) |-> !$past(i_eeprom_write_busy); endproperty
    a_ee: assert property (p_ee) else $error("operation began during eeprom write");
    property p_rb; o_rb_valid |-> $past(i_load_prog) && !o_ctrl_rdata[0] && !o_ctrl_rdata[3]; endproperty
    a_rb: assert property (p_rb) else $error("readback without load or bits kept");
endmodule
bind fsps_sequencer fsps_asserts #(.WORD_W(WORD_W), .NONUPD_FIRST_PAGE(NONUPD_FIRST_PAGE),
    .PROG_CYCLES(PROG_CYCLES)) fsps_asserts_inst (.*);
`default_nettype wire

// File: fsps_core_model.sv
// Processor core model: control write, then a store or load instruction
`default_nettype none
module fsps_core_model (
    input wire logic i_clk_sys,
    output logic o_ctrl_wr,
    output logic [7:0] o_ctrl_wdata,
    output logic o_store_prog,
    output logic o_load_prog
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {o_ctrl_wr, o_ctrl_wdata, o_store_prog, o_load_prog} = 11'h000;
    end
    // Idle cycle first, so an enable cleared by the last store has settled
    task automatic run(input logic [7:0] code, input int gap, input logic ld);
        @(negedge i_clk_sys);
        o_ctrl_wr = 1'h1;
        o_ctrl_wdata = code;
        @(negedge i_clk_sys);
        o_ctrl_wr = 1'h0;
        // Gap zero issues nothing and lets the window lapse
        if (gap > 0) begin
            repeat (gap - 1) @(negedge i_clk_sys);
            if (ld) o_load_prog = 1'h1;
            else o_store_prog = 1'h1;
            @(negedge i_clk_sys);
            {o_load_prog, o_store_prog} = 2'h0;
        end
    endtask
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking testbench for the flash self-programming sequencer
`include "fsps_consts.vh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk_sys = 0, i_reset_n = 0, i_ctrl_wr, i_store_prog, i_load_prog, i_eeprom_write_busy = 0;
    logic [7:0] i_ctrl_wdata, o_ctrl_rdata, i_data_low = 0, i_data_high = 0, i_fuse_low, i_fuse_high, o_rb_data;
    logic [15:0] i_zptr = 0, o_buf_rdata, exp_w [32];
    logic [3:0] i_fuse_ext, o_op_lock_data;
    logic [5:0] i_lock_bits;
    logic [4:0] i_buf_raddr = 0;
    logic [9:0] o_op_page;
    logic o_irq_req, o_cpu_halt, o_updatable_blocked, o_op_erase, o_op_write, o_op_lock, o_op_done, o_rb_valid;
    logic [31:0] seed = 32'h5508;
    int bad_count = 0, comparisons = 0, cyc = 0;
    // Short operation time keeps the run brief
    fsps_sequencer #(.PROG_CYCLES(20)) fsps_sequencer_inst (.*);
    fsps_core_model fsps_core_model_inst (.i_clk_sys(i_clk_sys), .o_ctrl_wr(i_ctrl_wr),
        .o_ctrl_wdata(i_ctrl_wdata), .o_store_prog(i_store_prog), .o_load_prog(i_load_prog));
    always #50 i_clk_sys = ~i_clk_sys;
    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Expected readback byte for a pointer value
    function automatic logic [7:0] rb_exp(input logic [15:0] z);
        case (z)
            `FSPS_RB_FUSE_LOW: return i_fuse_low;
            `FSPS_RB_LOCK: return {2'h3, i_lock_bits};
            `FSPS_RB_FUSE_EXT: return {4'hF, i_fuse_ext};
            `FSPS_RB_FUSE_HIGH: return i_fuse_high;
            default: return 8'hFF;
        endcase
    endfunction
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (e !== g) begin
            $display("wrong value %s expected %h seen %h", what, e, g);
            bad_count++;
        end
    endtask
    task automatic go(input logic [7:0] c, input int g, input logic l);
        fsps_core_model_inst.run(c, g, l);
    endtask
    // Waits for the end pulse under a bound, then one more cycle
    task automatic wait_done();
        int n;
        n = 0;
        while (o_op_done !== 1'h1 && n < 100) begin
            @(negedge i_clk_sys);
            n++;
        end
        if (n >= 100) chk("done pulse", 16'h1, 16'h0);
        @(negedge i_clk_sys);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (9) seed = lfsr(seed);
        {i_fuse_low, i_fuse_high, i_fuse_ext, i_lock_bits} = seed[25:0];
        repeat (6) @(negedge i_clk_sys);
        i_reset_n = 1;
        chk("ctrl reset", 16'h0, o_ctrl_rdata);
        chk("buffer reset", 16'hFFFF, o_buf_rdata);
        go(8'h80, 0, 0);
        chk("irq", 16'h1, o_irq_req);
        go(8'h87, 2, 0);
        chk("illegal code", 16'h80, o_ctrl_rdata);
        $display("test control done");
        // Distinct words, random data, random pointer bit 0 and arming gap
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            {i_data_high, i_data_low} = seed[15:0];
            exp_w[5'(k * 9)] = seed[15:0];
            i_zptr = {10'h002, 5'(k * 9), seed[16]};
            go(8'h81, seed[18:17] + 1, 0);
        end
        for (int k = 0; k < 4; k++) begin
            i_buf_raddr = 5'(k * 9);
            @(negedge i_clk_sys);
            chk("buffer word", exp_w[5'(k * 9)], o_buf_rdata);
        end
        i_data_low = ~i_data_low;
        i_zptr = 16'h0080;
        go(8'h81, 1, 0);
        i_buf_raddr = 5'h00;
        @(negedge i_clk_sys);
        chk("reload", exp_w[0], o_buf_rdata);
        $display("test buffer done");
        go(8'h83, 4, 0);
        chk("erase", {3'h6, 10'h002}, {o_op_erase, o_updatable_blocked, o_cpu_halt, o_op_page});
        wait_done();
        chk("after erase", 16'h1, {o_ctrl_rdata[0], o_ctrl_rdata[6]});
        go(8'h85, 1, 0);
        chk("write", {1'h1, 10'h002}, {o_op_write, o_op_page});
        wait_done();
        i_buf_raddr = 5'h09;
        @(negedge i_clk_sys);
        chk("buffer after write", 16'hFFFF, o_buf_rdata);
        i_zptr = 16'h008A;
        go(8'h81, 2, 0);
        chk("load clears busy", 16'h0, o_updatable_blocked);
        go(8'h91, 1, 0);
        i_buf_raddr = 5'h05;
        @(negedge i_clk_sys);
        chk("buffer after reenable", 16'hFFFF, o_buf_rdata);
        i_zptr = 16'h1900;
        go(8'h83, 3, 0);
        chk("halt", 16'h1, o_cpu_halt);
        wait_done();
        $display("test programming done");
        seed = lfsr(seed);
        i_data_low = seed[7:0] | 8'hC3;
        i_zptr = seed[31:16];
        go(8'h89, 2, 0);
        chk("lock", {1'h1, i_data_low[5:2], 2'h0}, {o_op_lock, o_op_lock_data, o_cpu_halt, o_updatable_blocked});
        wait_done();
        for (int k = 0; k < 5; k++) begin
            i_zptr = 16'(k);
            go(8'h89, k % 3 + 1, 1);
            chk("readback", {1'h1, rb_exp(i_zptr)}, {o_rb_valid, o_rb_data});
            chk("lock bits clear", 16'h0, {o_ctrl_rdata[3], o_ctrl_rdata[0]});
        end
        go(8'h83, 0, 0);
        repeat (5) @(negedge i_clk_sys);
        chk("window lapse", 16'h80, o_ctrl_rdata);
        $display("test lock done");
        i_zptr = 16'h0084;
        go(8'h81, 1, 0);
        i_eeprom_write_busy = 1;
        @(negedge i_clk_sys);
        i_eeprom_write_busy = 0;
        i_buf_raddr = 5'h02;
        @(negedge i_clk_sys);
        chk("discarded buffer", 16'hFFFF, o_buf_rdata);
        i_eeprom_write_busy = 1;
        go(8'h83, 2, 0);
        chk("eeprom block", 16'h080, {o_op_erase, o_ctrl_rdata});
        i_eeprom_write_busy = 0;
        $display("test eeprom done");
        // Signature read refused, then a load that a mid-run reset wipes
        i_zptr = 16'h0086;
        go(8'hA1, 1, 0);
        i_buf_raddr = 5'h03;
        @(negedge i_clk_sys);
        chk("signature refused", 16'hFFFF, o_buf_rdata);
        go(8'h81, 1, 0);
        @(negedge i_clk_sys);
        chk("loaded before reset", {i_data_high, i_data_low}, o_buf_rdata);
        i_reset_n = 0;
        @(negedge i_clk_sys);
        i_reset_n = 1;
        chk("ctrl after reset", 16'h0, o_ctrl_rdata);
        @(negedge i_clk_sys);
        chk("buffer after reset", 16'hFFFF, o_buf_rdata);
        $display("test reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
